/* src/dsa_sync_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defs.svh"
module dsa_sync_top #(
  parameter int W = 16,
  parameter int DEPTH = 256,
  parameter int DI_N = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sync_input_a_i,
  input wire logic sync_input_b_i,
  input wire logic ref_clock_in_i,
  input wire logic chain_trigger_input_i,
  input wire logic [DI_N-1:0] digital_inputs_i,
  input wire dsa_pkg::dsa_ref_src_e ref_src_i,
  input wire logic ref_edge_fall_i,
  input wire logic ref_rate_slow_i,
  input wire dsa_pkg::dsa_start_src_e start_src_i,
  input wire logic start_edge_fall_i,
  input wire logic sw_start_i,
  input wire logic sw_stop_i,
  input wire logic [21:0] switch_period_cycles_i,
  input wire logic [20:0] interframe_delay_i,
  input wire logic [8:0] table_len_i,
  input wire logic tbl_wr_i,
  input wire logic [7:0] tbl_addr_i,
  input wire logic [4:0] tbl_chan_i,
  input wire logic [7:0] tbl_avg_i,
  input wire logic [W-1:0] adc_data_i,
  input wire logic adc_valid_i,
  input wire dsa_pkg::dsa_gate_src_e gate_src_i,
  input wire logic [4:0] gate_dig_sel_i,
  input wire logic [4:0] gate_ana_chan_i,
  input wire logic [W-1:0] gate_ana_threshold_i,
  input wire logic gate_ana_below_i,
  input wire logic gate_edge_mode_i,
  input wire logic gate_edge_fall_i,
  input wire logic sw_inhibit_i,
  input wire logic auto_inhibit_en_i,
  input wire logic [31:0] frame_limit_i,
  output logic ref_clock_out_o,
  output logic chain_trigger_output_o,
  output logic conv_start_o,
  output logic running_o,
  output logic armed_o,
  output logic async_out_allow_o,
  output logic [4:0] channel_o,
  output logic [W-1:0] sample_o,
  output logic [7:0] sample_lch_o,
  output logic sample_valid_o,
  output logic gate_open_o
);
  localparam int CLK_MHZ = `DSA_CLK_HZ / 1000000;
  localparam int REF_FAST_CYC = `DSA_CLK_HZ / `DSA_REF_FAST_HZ;
  localparam int REF_SLOW_CYC = `DSA_CLK_HZ / `DSA_REF_SLOW_HZ;
  localparam int TW_CYC = (`DSA_TW_NS * CLK_MHZ + 999) / 1000;
  localparam int EXT_WAIT_CYC = `DSA_EXT_WAIT_NS * CLK_MHZ / 1000;

  if (DEPTH < 1 || DEPTH > 256 || DI_N < 1 || DI_N > 16 || W > 16) begin : g_bad_cfg
    $error("dsa_sync_top: DEPTH 1..256, DI_N 1..16, W up to 16 only");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DELAY} dsa_seq_e;

  // two-stage synchronisers, then one more stage for edge finding
  localparam int NS = DI_N + 4;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] s3_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {digital_inputs_i, chain_trigger_input_i, ref_clock_in_i, sync_input_b_i, sync_input_a_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  wire [NS-1:0] rise = s2_q & ~s3_q;
  wire [NS-1:0] fall = ~s2_q & s3_q;

  wire ref_internal = (ref_src_i == dsa_pkg::DSA_REF_INTERNAL);
  wire start_software = (start_src_i == dsa_pkg::DSA_START_SOFTWARE);
  wire [1:0] ref_idx = 2'(ref_src_i) - 2'h1;
  wire [1:0] st_idx = 2'(start_src_i) - 2'h1;
  wire ext_ref_edge = (ref_src_i == dsa_pkg::DSA_REF_CHAIN) ? rise[2]
                    : (ref_edge_fall_i ? fall[ref_idx] : rise[ref_idx]);
  wire ext_start_edge = (start_src_i == dsa_pkg::DSA_START_CHAIN) ? rise[3]
                      : (start_edge_fall_i ? fall[st_idx] : rise[st_idx]);

  logic run_q;
  logic armed_q;
  logic [5:0] div_q;
  logic [5:0] stale_q;
  logic [2:0] tw_q;
  wire [5:0] div_last = ref_rate_slow_i ? 6'(REF_SLOW_CYC - 1) : 6'(REF_FAST_CYC - 1);
  wire start_ev = !run_q && (start_software ? sw_start_i : (armed_q && ext_start_edge));
  wire tick = run_q && (ref_internal ? (div_q == 6'h00) : ext_ref_edge);
  wire ext_stale = !ref_internal && run_q && (stale_q >= 6'(EXT_WAIT_CYC));
  wire allow_d = (ref_internal && start_software) || (!armed_q && !ext_stale);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_q <= 1'b0;
      armed_q <= 1'b0;
      div_q <= 6'h00;
      stale_q <= 6'h00;
      tw_q <= 3'h0;
    end else begin
      // stop is software only and does not wait for a reference edge
      if (sw_stop_i) begin
        run_q <= 1'b0;
        armed_q <= 1'b0;
      end else if (start_ev) begin
        run_q <= 1'b1;
        armed_q <= 1'b0;
      end else if (sw_start_i && !run_q) begin
        armed_q <= 1'b1;
      end
      div_q <= (start_ev || div_q >= div_last) ? 6'h00 : div_q + 6'h01;
      if (ext_ref_edge || !run_q) begin
        stale_q <= 6'h00;
      end else if (stale_q < 6'(EXT_WAIT_CYC)) begin
        stale_q <= stale_q + 6'h01;
      end
      tw_q <= tick ? 3'(TW_CYC) : (tw_q != 3'h0 ? tw_q - 3'h1 : 3'h0);
    end
  end

  // control table, flip-flop storage
  dsa_pkg::dsa_entry_s tbl_q [DEPTH];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        tbl_q[i] <= '{chan: `DSA_CHAN_DEFAULT, avg: `DSA_AVG_DEFAULT};
      end
    end else if (tbl_wr_i && 32'(tbl_addr_i) < DEPTH) begin
      tbl_q[tbl_addr_i] <= '{chan: tbl_chan_i, avg: tbl_avg_i};
    end
  end

  dsa_seq_e seq_q;
  logic [7:0] idx_q;
  logic [21:0] swc_q;
  logic [20:0] dly_q;
  dsa_pkg::dsa_entry_s cur;
  assign cur = tbl_q[idx_q];
  wire [21:0] avg_ext = {14'h0000, cur.avg};
  // a count larger than the period simply uses every sample
  wire [21:0] settle = (avg_ext >= switch_period_cycles_i) ? 22'h000000
                     : switch_period_cycles_i - avg_ext;
  wire per_last = (swc_q + 22'h000001 >= switch_period_cycles_i);
  wire tbl_last = ({1'b0, idx_q} + 9'h001 >= table_len_i);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seq_q <= ST_IDLE;
      idx_q <= 8'h00;
      swc_q <= 22'h000000;
      dly_q <= 21'h000000;
    end else if (!run_q) begin
      seq_q <= ST_IDLE;
      idx_q <= 8'h00;
      swc_q <= 22'h000000;
    end else if (tick) begin
      unique case (seq_q)
        ST_IDLE, ST_FRAME: begin
          seq_q <= ST_FRAME;
          swc_q <= per_last ? 22'h000000 : swc_q + 22'h000001;
          if (per_last) begin
            idx_q <= tbl_last ? 8'h00 : idx_q + 8'h01;
            if (tbl_last && interframe_delay_i != 21'h000000) begin
              seq_q <= ST_DELAY;
              dly_q <= interframe_delay_i - 21'h000001;
            end
          end
        end
        ST_DELAY: begin
          // table stays on its first entry throughout the gap
          idx_q <= 8'h00;
          if (dly_q == 21'h000000) begin
            seq_q <= ST_FRAME;
          end else begin
            dly_q <= dly_q - 21'h000001;
          end
        end
      endcase
    end
  end

  // tag of the conversion in flight; its result must return before the next tick
  logic pend_use_q;
  logic pend_last_q;
  logic pend_flast_q;
  logic [7:0] pend_lch_q;
  logic [4:0] pend_chan_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_use_q <= 1'b0;
      pend_last_q <= 1'b0;
      pend_flast_q <= 1'b0;
      pend_lch_q <= 8'h00;
      pend_chan_q <= 5'h00;
    end else if (tick) begin
      pend_use_q <= (seq_q != ST_DELAY) && (swc_q >= settle);
      pend_last_q <= (seq_q != ST_DELAY) && per_last;
      pend_flast_q <= (seq_q != ST_DELAY) && per_last && tbl_last;
      pend_lch_q <= idx_q;
      pend_chan_q <= cur.chan;
    end
  end

  dsa_avg_if #(.W(W)) avg_bus ();
  assign avg_bus.sample = adc_data_i;
  assign avg_bus.valid = adc_valid_i;
  assign avg_bus.use_it = pend_use_q;
  assign avg_bus.last = pend_last_q;
  assign avg_bus.clear = !run_q;
  dsa_averager #(.W(W)) u_avg (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .bus(avg_bus)
  );

  // secondary gating: a selector on the running stream only
  logic ana_lvl_q;
  logic cond_prev_q;
  logic blocked_q;
  logic edge_open_q;
  logic [31:0] frames_q;
  wire ana_hit = adc_valid_i && (pend_chan_q == gate_ana_chan_i);
  wire ana_cmp = gate_ana_below_i ? (signed'(adc_data_i) < signed'(gate_ana_threshold_i))
                                  : (signed'(adc_data_i) > signed'(gate_ana_threshold_i));
  wire [NS-3:0] dig_src = {s2_q[NS-1:4], s2_q[1:0]};
  wire dig_lvl = (gate_dig_sel_i < 5'(DI_N)) ? dig_src[gate_dig_sel_i + 5'h2]
               : (gate_dig_sel_i == 5'(DI_N) ? s2_q[0] : s2_q[1]);
  wire cond = (gate_src_i == dsa_pkg::DSA_GATE_ANALOG) ? ana_lvl_q
            : (gate_src_i == dsa_pkg::DSA_GATE_DIGITAL) ? dig_lvl : 1'b1;
  wire cond_edge = gate_edge_fall_i ? (!cond && cond_prev_q) : (cond && !cond_prev_q);
  // a frame counts when its last sample leaves, so the final frame is still delivered
  wire frame_done = avg_bus.result_valid && pend_flast_q;
  wire limit_hit = auto_inhibit_en_i && frame_done && pass && (frames_q + 32'h1 >= frame_limit_i);
  wire inhibit = sw_inhibit_i || limit_hit;
  wire gate_none = (gate_src_i != dsa_pkg::DSA_GATE_ANALOG) && (gate_src_i != dsa_pkg::DSA_GATE_DIGITAL);
  wire pass = run_q && ((gate_edge_mode_i && !gate_none) ? edge_open_q : (cond && !blocked_q));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ana_lvl_q <= 1'b0;
      cond_prev_q <= 1'b0;
      blocked_q <= 1'b0;
      edge_open_q <= 1'b0;
      frames_q <= 32'h0;
    end else begin
      if (ana_hit) begin
        ana_lvl_q <= ana_cmp;
      end
      cond_prev_q <= cond;
      // a repeated condition re-opens the gate; primary train keeps running
      if (inhibit) begin
        blocked_q <= 1'b1;
        edge_open_q <= 1'b0;
        frames_q <= 32'h0;
      end else begin
        if (cond_edge && run_q) begin
          blocked_q <= 1'b0;
          edge_open_q <= 1'b1;
        end
        if (frame_done && pass) begin
          frames_q <= frames_q + 32'h1;
        end
      end
      if (!run_q) begin
        blocked_q <= 1'b0;
        edge_open_q <= 1'b0;
        frames_q <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_clock_out_o <= 1'b0;
      chain_trigger_output_o <= 1'b0;
      conv_start_o <= 1'b0;
      running_o <= 1'b0;
      armed_o <= 1'b0;
      async_out_allow_o <= 1'b1;
      channel_o <= 5'h00;
      sample_o <= '0;
      sample_lch_o <= 8'h00;
      sample_valid_o <= 1'b0;
      gate_open_o <= 1'b0;
    end else begin
      ref_clock_out_o <= tick || (tw_q > 3'h1);
      chain_trigger_output_o <= run_q;
      conv_start_o <= tick;
      running_o <= run_q;
      armed_o <= armed_q;
      async_out_allow_o <= allow_d;
      channel_o <= cur.chan;
      sample_valid_o <= avg_bus.result_valid && pass;
      if (avg_bus.result_valid) begin
        sample_o <= avg_bus.result;
        sample_lch_o <= pend_lch_q;
      end
      gate_open_o <= pass;
    end
  end
endmodule : dsa_sync_top
`default_nettype wire

/* src/dsa_defs.svh */
`ifndef DSA_DEFS_SVH
`define DSA_DEFS_SVH

// module clock and internal reference rates
`define DSA_CLK_HZ 50000000
`define DSA_REF_FAST_HZ 2000000
`define DSA_REF_SLOW_HZ 1500000

// reference pulse width on the chain output
`define DSA_TW_NS 50
// longest wait for an external reference edge before async output is refused
`define DSA_EXT_WAIT_NS 1000

// control-table defaults and limits
`define DSA_AVG_DEFAULT 8'h01
`define DSA_AVG_MAX 128
`define DSA_CHAN_DEFAULT 5'h00

// accumulator width for averaging
`define DSA_ACC_W 24

`endif

/* src/dsa_pkg.sv */
package dsa_pkg;

  typedef enum logic [1:0] {
    DSA_REF_INTERNAL,
    DSA_REF_SYNC_A,
    DSA_REF_SYNC_B,
    DSA_REF_CHAIN
  } dsa_ref_src_e;

  typedef enum logic [1:0] {
    DSA_START_SOFTWARE,
    DSA_START_SYNC_A,
    DSA_START_SYNC_B,
    DSA_START_CHAIN
  } dsa_start_src_e;

  typedef enum logic [1:0] {
    DSA_GATE_NONE,
    DSA_GATE_ANALOG,
    DSA_GATE_DIGITAL,
    DSA_GATE_RESERVED
  } dsa_gate_src_e;

  typedef struct packed {
    logic [4:0] chan;
    logic [7:0] avg;
  } dsa_entry_s;

endpackage : dsa_pkg

/* src/dsa_avg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dsa_avg_if #(
  parameter int W = 16
);
  logic [W-1:0] sample;
  logic valid;
  logic use_it;
  logic last;
  logic [W-1:0] result;
  logic result_valid;
  logic clear;

  modport ctl (output sample, output valid, output use_it, output last, output clear, input result, input result_valid);
  modport avg (input sample, input valid, input use_it, input last, input clear, output result, output result_valid);
endinterface : dsa_avg_if
`default_nettype wire

/* src/dsa_averager.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defs.svh"
module dsa_averager #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  dsa_avg_if.avg bus
);
  localparam int AW = `DSA_ACC_W;

  logic signed [AW-1:0] acc_q;
  logic signed [AW-1:0] acc_d;
  logic [7:0] n_q;
  logic [7:0] n_d;
  logic signed [AW-1:0] quot;
  logic [W-1:0] result_q;
  logic result_valid_q;

  wire take = bus.valid && bus.use_it;
  wire signed [AW-1:0] sample_ext = AW'(signed'(bus.sample));

  // sum restarts after each switching period; 128 x 16-bit fits in 24 bits
  assign acc_d = take ? acc_q + sample_ext : acc_q;
  assign n_d = take ? n_q + 8'h01 : n_q;
  // divide by the samples really taken, so a count above the period stays exact
  assign quot = (n_d == 8'h00) ? acc_d : acc_d / signed'({16'h0000, n_d});

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q <= '0;
      n_q <= 8'h00;
      result_q <= '0;
      result_valid_q <= 1'b0;
    end else if (bus.clear) begin
      // a stop mid-period must not leak a partial sum into the next run
      acc_q <= '0;
      n_q <= 8'h00;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= bus.valid && bus.last;
      if (bus.valid && bus.last) begin
        result_q <= quot[W-1:0];
        acc_q <= '0;
        n_q <= 8'h00;
      end else begin
        acc_q <= acc_d;
        n_q <= n_d;
      end
    end
  end

  assign bus.result = result_q;
  assign bus.result_valid = result_valid_q;
endmodule : dsa_averager
`default_nettype wire

/* dv/dsa_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dsa_master_model #(
  parameter int HALF_NS = 340
) (
  input wire logic en_i,
  output logic ref_clock_o,
  output logic trig_o
);
  // reference stands low between frames; a frame ends only after a full period
  initial begin
    ref_clock_o = 1'b0;
    trig_o = 1'b0;
    forever begin
      wait (en_i);
      trig_o = 1'b1;
      while (en_i) begin
        #(HALF_NS) ref_clock_o = 1'b1;
        #(HALF_NS) ref_clock_o = 1'b0;
      end
      trig_o = 1'b0;
    end
  end
endmodule : dsa_master_model
`default_nettype wire

/* dv/dsa_sync_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dsa_sync_top_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire dsa_pkg::dsa_ref_src_e ref_src_i,
  input wire logic ref_rate_slow_i,
  input wire dsa_pkg::dsa_start_src_e start_src_i,
  input wire logic sw_start_i,
  input wire logic sw_stop_i,
  input wire logic adc_valid_i,
  input wire logic ref_clock_out_o,
  input wire logic chain_trigger_output_o,
  input wire logic conv_start_o,
  input wire logic running_o,
  input wire logic armed_o,
  input wire logic async_out_allow_o,
  input wire logic sample_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [5:0] gap_q;
  logic seen_q;
  logic internal_w;
  assign internal_w = (ref_src_i == dsa_pkg::DSA_REF_INTERNAL) && (start_src_i == dsa_pkg::DSA_START_SOFTWARE);
  // the gap is only trusted after one tick of the current run
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap_q <= 6'h00;
      seen_q <= 1'b0;
    end else begin
      gap_q <= conv_start_o ? 6'h00 : gap_q + 6'h01;
      seen_q <= running_o && (seen_q || conv_start_o);
    end
  end
  sequence s_sw_start;
    sw_start_i && !sw_stop_i && !running_o && start_src_i == dsa_pkg::DSA_START_SOFTWARE;
  endsequence
  sequence s_ref_pulse;
    ref_clock_out_o [*3] ##1 !ref_clock_out_o;
  endsequence
  a_start_runs: assert property (s_sw_start |-> ##2 running_o)
    else $error("software start did not raise running");
  a_stop_halts: assert property (sw_stop_i |-> ##2 !running_o)
    else $error("stop did not clear running");
  a_chain_level: assert property (chain_trigger_output_o == running_o)
    else $error("chain start output differs from running");
  a_ref_width: assert property ($rose(ref_clock_out_o) |-> s_ref_pulse)
    else $error("reference output pulse width wrong");
  a_conv_with_ref: assert property (conv_start_o |-> $rose(ref_clock_out_o))
    else $error("converter start not aligned with reference output");
  a_int_period: assert property (conv_start_o && seen_q && ref_src_i == dsa_pkg::DSA_REF_INTERNAL
      |-> gap_q == (ref_rate_slow_i ? 6'h20 : 6'h18))
    else $error("internal reference period wrong");
  a_int_allow: assert property (running_o && internal_w && !armed_o |-> async_out_allow_o)
    else $error("async output refused under internal sync");
  a_armed_block: assert property (armed_o [*2] |-> !async_out_allow_o)
    else $error("async output allowed while armed");
  a_sample_lat: assert property (sample_valid_o |-> $past(adc_valid_i, 2))
    else $error("sample not two cycles after converter result");
endmodule : dsa_sync_top_chk
bind dsa_sync_top dsa_sync_top_chk u_dsa_sync_top_chk (.*);
`default_nettype wire

/* dv/dsa_sync_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dsa_sync_top_tb;
  localparam int W = 16;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:1] en = 3'h0;
  logic sync_input_a_i, sync_input_b_i, ref_clock_in_i, chain_trigger_input_i;
  logic [15:0] digital_inputs_i = 16'h0000;
  dsa_pkg::dsa_ref_src_e ref_src_i = dsa_pkg::DSA_REF_INTERNAL;
  dsa_pkg::dsa_start_src_e start_src_i = dsa_pkg::DSA_START_SOFTWARE;
  dsa_pkg::dsa_gate_src_e gate_src_i = dsa_pkg::DSA_GATE_NONE;
  logic ref_edge_fall_i = 1'b0, ref_rate_slow_i = 1'b0, start_edge_fall_i = 1'b0, adc_valid_i = 1'b0;
  logic sw_start_i = 1'b0, sw_stop_i = 1'b0, sw_inhibit_i = 1'b0, tbl_wr_i = 1'b0;
  logic gate_ana_below_i = 1'b0, gate_edge_mode_i = 1'b0, gate_edge_fall_i = 1'b0, auto_inhibit_en_i = 1'b0;
  logic [21:0] switch_period_cycles_i = 22'h000001;
  logic [20:0] interframe_delay_i = 21'h000000;
  logic [8:0] table_len_i = 9'h001;
  logic [7:0] tbl_addr_i = 8'h00, tbl_avg_i = 8'h01, sample_lch_o;
  logic [4:0] tbl_chan_i = 5'h00, gate_dig_sel_i = 5'h00, gate_ana_chan_i = 5'h00, channel_o;
  logic [W-1:0] adc_data_i = 16'h0000, gate_ana_threshold_i = 16'h0000, sample_o, exp_sample;
  logic [31:0] frame_limit_i = 32'h00000002;
  logic ref_clock_out_o, chain_trigger_output_o, conv_start_o, running_o, armed_o, async_out_allow_o;
  logic sample_valid_o, gate_open_o;
  logic [W-1:0] buf_q [0:7];
  logic [1:0] cs = 2'h0;
  int errors = 0, check_count = 0, seed = 82, nsamp = 0, nconv = 0, idx = 0, nsw = 1, navg = 1, e;

  always #10 clk_i = ~clk_i;
  dsa_sync_top u_dsa_sync_top (.*);
  dsa_master_model u_dsa_master_model_a (.en_i(en[1]), .ref_clock_o(sync_input_a_i), .trig_o());
  dsa_master_model u_dsa_master_model_b (.en_i(en[2]), .ref_clock_o(sync_input_b_i), .trig_o());
  dsa_master_model u_dsa_master_model_m (.en_i(en[3]), .ref_clock_o(ref_clock_in_i), .trig_o(chain_trigger_input_i));

  function automatic logic [W-1:0] exp_avg(input int n, input int a);
    logic [23:0] s;
    s = 24'h000000;
    for (int k = n - a; k < n; k++)
      s += 24'(buf_q[k]);
    return W'(s / 24'(a));
  endfunction : exp_avg

  function automatic int exp_conv(input int i);
    return 300 / (i % 4 != 0 ? 34 : (i == 4 ? 33 : 25));
  endfunction : exp_conv

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cycles

  task automatic pulse(ref logic s);
    s = 1'b1;
    cycles(1);
    s = 1'b0;
  endtask : pulse

  task automatic wait_run(input logic want);
    int k;
    k = 0;
    while (running_o !== want && k < 400) begin
      cycles(1);
      k++;
    end
    if (k == 400) begin
      errors++;
      give_verdict();
    end
  endtask : wait_run

  task automatic stop_run();
    pulse(sw_stop_i);
    cycles(2);
    check("stopped", {running_o, chain_trigger_output_o}, 2'b00);
  endtask : stop_run

  task automatic gate_phase(input logic [15:0] di, input logic want);
    digital_inputs_i = di;
    cycles(30);
    nsamp = 0;
    cycles(250);
    check("gate_pass", nsamp > 0, want);
    check("gate_open", gate_open_o, want);
  endtask : gate_phase

  // converter stand-in: answers each start two cycles later, positive codes only
  always @(posedge clk_i) cs <= {cs[0], conv_start_o};
  always @(posedge clk_i) begin
    #1;
    adc_valid_i = cs[1];
    if (cs[1])
      adc_data_i = {1'b0, 15'($random(seed))};
  end

  always @(posedge clk_i) begin
    if (conv_start_o)
      nconv++;
    if (sample_valid_o) begin
      nsamp++;
      check("sample", sample_o, exp_sample);
      check("sample_lch", sample_lch_o, 8'h00);
    end
    if (!running_o)
      idx = 0;
    else if (adc_valid_i) begin
      buf_q[idx] = adc_data_i;
      if (idx == nsw - 1) begin
        exp_sample = exp_avg(nsw, navg);
        idx = 0;
      end else
        idx++;
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    check("allow_rst", async_out_allow_o, 1'b1);
    #1 arst_n_i = 1'b1;
    for (int i = 0; i < 5; i++) begin
      ref_src_i = dsa_pkg::dsa_ref_src_e'(i % 4);
      start_src_i = dsa_pkg::dsa_start_src_e'(i % 4);
      ref_rate_slow_i = (i == 4);
      cycles(3);
      pulse(sw_start_i);
      if (i % 4 != 0) begin
        cycles(60);
        check("armed", {armed_o, async_out_allow_o}, 2'b10);
        en[i] = 1'b1;
      end
      wait_run(1'b1);
      nconv = 0;
      cycles(300);
      e = exp_conv(i);
      check("conv_rate", nconv >= e - 1 && nconv <= e + 1, 1'b1);
      check("run_hold", {running_o, chain_trigger_output_o}, 2'b11);
      if (i % 4 == 0)
        check("allow_int", async_out_allow_o, 1'b1);
      else begin
        // a silent master must drop async output but never halt the train
        en = 3'h0;
        cycles(100);
        check("stale", {running_o, async_out_allow_o}, 2'b10);
      end
      stop_run();
      en = 3'h0;
      $display("test source %0d done", i);
    end
    for (int r = 0; r < 4; r++) begin
      nsw = (r == 0) ? 3 : 1 + ($unsigned($random(seed)) % 6);
      if (r > 0) begin
        navg = 1 + ($unsigned($random(seed)) % nsw);
        tbl_chan_i = 5'($random(seed));
        tbl_avg_i = 8'(navg);
        pulse(tbl_wr_i);
      end
      switch_period_cycles_i = 22'(nsw);
      pulse(sw_start_i);
      wait_run(1'b1);
      nsamp = 0;
      cycles(125 * nsw);
      check("samples", nsamp >= 4, 1'b1);
      check("channel", channel_o, tbl_chan_i);
      stop_run();
      $display("test average %0d done", r);
    end
    nsw = 1;
    navg = 1;
    tbl_avg_i = 8'h01;
    pulse(tbl_wr_i);
    switch_period_cycles_i = 22'h000001;
    gate_src_i = dsa_pkg::DSA_GATE_DIGITAL;
    gate_dig_sel_i = 5'($unsigned($random(seed)) % 16);
    pulse(sw_start_i);
    wait_run(1'b1);
    gate_phase(16'h0000, 1'b0);
    gate_phase(16'hffff, 1'b1);
    pulse(sw_inhibit_i);
    gate_phase(16'hffff, 1'b0);
    gate_phase(16'h0000, 1'b0);
    gate_phase(16'hffff, 1'b1);
    gate_edge_mode_i = 1'b1;
    gate_edge_fall_i = 1'b1;
    pulse(sw_inhibit_i);
    gate_phase(16'hffff, 1'b0);
    gate_phase(16'h0000, 1'b1);
    stop_run();
    $display("test gating done");
    gate_src_i = dsa_pkg::DSA_GATE_NONE;
    auto_inhibit_en_i = 1'b1;
    frame_limit_i = 32'(2 + $unsigned($random(seed)) % 3);
    pulse(sw_start_i);
    wait_run(1'b1);
    nsamp = 0;
    cycles(400);
    check("frame_limit", nsamp, frame_limit_i);
    stop_run();
    nsamp = 0;
    cycles(100);
    check("idle_samples", nsamp, 0);
    $display("test frame limit done");
    give_verdict();
  end
endmodule : dsa_sync_top_tb
`default_nettype wire
